// *** core/ocs_pkg.sv ***
`default_nettype none

package ocs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OCS_ADDR_CTRL   = 8'h63;
	localparam logic [7:0] OCS_ADDR_RSVD_A = 8'h64;
	localparam logic [7:0] OCS_ADDR_RSVD_B = 8'h65;
	localparam logic [7:0] OCS_ADDR_RSVD_C = 8'h66;
	localparam logic [7:0] OCS_ADDR_RSVD_D = 8'h67;

	// ----------------------------------------------------------------
	// Field positions in the control register
	// ----------------------------------------------------------------
	localparam int OCS_SYNC_BIT     = 7;
	localparam int OCS_SEL3_LSB     = 4;
	localparam int OCS_SEL2_LSB     = 0;
	localparam int OCS_SEL_W        = 2;

	// ----------------------------------------------------------------
	// Values after reset and the value read from unmapped addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OCS_CTRL_RST   = 8'h00;
	localparam logic [7:0] OCS_RSVD_RST   = 8'h00;
	localparam logic [7:0] OCS_RSVD_D_RST = 8'hA0;
	localparam logic [7:0] OCS_UNMAPPED   = 8'h00;

	// ----------------------------------------------------------------
	// Source codes and outputs
	// ----------------------------------------------------------------
	localparam logic [1:0] OCS_SRC_PLL  = 2'h0;
	localparam logic [1:0] OCS_SRC_REF0 = 2'h1;
	localparam logic [1:0] OCS_SRC_REF1 = 2'h2;
	localparam logic [1:0] OCS_SRC_XTAL = 2'h3;
	localparam int         OCS_NUM_OUT  = 4;
	localparam int         OCS_NUM_SRC  = 4;

	// Turns a source code into a one-hot route (bit 0 PLL .. bit 3 crystal).
	function automatic logic [3:0] ocs_route(input logic [1:0] code);
		logic [3:0] r;
		r = 4'h0;
		case (code)
			OCS_SRC_PLL:  r = 4'h1;
			OCS_SRC_REF0: r = 4'h2;
			OCS_SRC_REF1: r = 4'h4;
			OCS_SRC_XTAL: r = 4'h8;
			default:      r = 4'h0;
		endcase
		return r;
	endfunction

endpackage

`default_nettype wire

// *** core/ocs_sync_if.sv ***
`default_nettype none

interface ocs_sync_if #(
	parameter int NUM_OUT = 4
);
	logic               sync_bit;     // Synchronisation control bit.
	logic [NUM_OUT-1:0] pll_derived;  // Outputs currently fed by the PLL.
	logic [NUM_OUT-1:0] hold;         // Divider held in reset.
	logic [NUM_OUT-1:0] phase_zero;   // Coarse phase cleared on release.

	modport ctl (output sync_bit, output pll_derived, input hold, input phase_zero);
	modport sync (input sync_bit, input pll_derived, output hold, output phase_zero);
endinterface

`default_nettype wire

// *** core/ocs_divider_sync.sv ***
`default_nettype none

module ocs_divider_sync
	import ocs_pkg::*;
#(
	parameter int NUM_OUT = OCS_NUM_OUT
) (
	input  wire logic clk,     // Clock.
	input  wire logic rst,     // Synchronous reset, active high.
	ocs_sync_if.sync  sif      // Hold and release towards the dividers.
);

	typedef struct packed {
		logic               prev;
		logic [NUM_OUT-1:0] hold;
		logic [NUM_OUT-1:0] pz;
	} ocs_sync_state_t;

	ocs_sync_state_t state_ff;
	ocs_sync_state_t nxt_state;

	// ----------------------------------------------------------------
	// Hold and simultaneous release
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state      = state_ff;
		nxt_state.prev = sif.sync_bit;
		nxt_state.pz   = '0;
		if (sif.sync_bit) begin
			nxt_state.hold = sif.pll_derived;
		end else begin
			nxt_state.hold = '0;
		end
		if (state_ff.prev && !sif.sync_bit) begin
			nxt_state.pz = state_ff.hold;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sif.hold       = state_ff.hold;
	assign sif.phase_zero = state_ff.pz;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_hold_while_set;
		@(posedge clk) disable iff (rst)
		sif.sync_bit |=> (sif.hold == $past(sif.pll_derived));
	endproperty
	a_hold_while_set: assert property (p_hold_while_set)
		else $error("dividers not held while sync bit set");

	property p_release_together;
		@(posedge clk) disable iff (rst)
		(state_ff.prev && !sif.sync_bit) |=> (sif.hold == '0);
	endproperty
	a_release_together: assert property (p_release_together)
		else $error("dividers not released together");

	property p_phase_on_release;
		@(posedge clk) disable iff (rst)
		(state_ff.prev && !sif.sync_bit && (sif.hold != '0))
			|=> (sif.phase_zero == $past(sif.hold)) ##1 (sif.phase_zero == '0);
	endproperty
	a_phase_on_release: assert property (p_phase_on_release)
		else $error("phase not cleared once on release");

	property p_phase_only_release;
		@(posedge clk) disable iff (rst)
		(sif.phase_zero != '0) |-> $past(state_ff.prev) && !$past(sif.sync_bit);
	endproperty
	a_phase_only_release: assert property (p_phase_only_release)
		else $error("phase cleared without a release");

endmodule

`default_nettype wire

// *** core/ocs_output_clock_source_sync.sv ***
// Notes on behaviour
// - Sync bit rising holds every PLL-fed output divider in reset while set.
// - Sync bit falling releases all held dividers in the same cycle.
// - On that release each released output's coarse phase is cleared to zero.
// - Pair two and three selectors route 00 PLL, 01 ref0, 10 ref1, 11 crystal.
`default_nettype none

module ocs_output_clock_source_sync
	import ocs_pkg::*;
(
	input  wire logic       clk,                      // Clock, 250 MHz.
	input  wire logic       rst,                      // Synchronous reset, active high.
	input  wire logic [7:0] reg_addr,                 // Register address.
	input  wire logic [7:0] reg_wdata,                // Write data.
	input  wire logic       reg_wr,                   // Write strobe.
	input  wire logic       reg_rd,                   // Read strobe.
	output logic      [7:0] reg_rdata,                // Read data.
	output logic            reg_rvalid,               // Read data valid pulse.
	output logic      [3:0] div_hold,                 // Per-output divider hold.
	output logic      [3:0] phase_zero,               // Per-output coarse phase clear.
	output logic      [1:0] pair_two_source_select,   // Pair two source code.
	output logic      [1:0] pair_three_source_select, // Pair three source code.
	output logic      [3:0] pair_two_route,           // Pair two one-hot route.
	output logic      [3:0] pair_three_route          // Pair three one-hot route.
);

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rsvd_a;
		logic [7:0] rsvd_b;
		logic [7:0] rsvd_c;
		logic [7:0] rsvd_d;
		logic [7:0] rdata;
		logic       rvalid;
		logic [3:0] route2;
		logic [3:0] route3;
	} ocs_top_state_t;

	ocs_top_state_t state_ff;
	ocs_top_state_t nxt_state;

	ocs_sync_if #(.NUM_OUT(OCS_NUM_OUT)) sif ();

	logic [1:0] sel2;
	logic [1:0] sel3;

	assign sel2 = state_ff.ctrl[OCS_SEL2_LSB +: OCS_SEL_W];
	assign sel3 = state_ff.ctrl[OCS_SEL3_LSB +: OCS_SEL_W];

	// ----------------------------------------------------------------
	// Divider synchronisation
	// ----------------------------------------------------------------
	// Pairs zero and one always run from the PLL; two and three only on code 00.
	assign sif.sync_bit    = state_ff.ctrl[OCS_SYNC_BIT];
	assign sif.pll_derived = {sel3 == OCS_SRC_PLL, sel2 == OCS_SRC_PLL, 2'b11};

	ocs_divider_sync #(
		.NUM_OUT (OCS_NUM_OUT)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.sif (sif.sync)
	);

	// ----------------------------------------------------------------
	// Register access and source routing
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.rvalid = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				OCS_ADDR_CTRL:   nxt_state.ctrl   = reg_wdata;
				OCS_ADDR_RSVD_A: nxt_state.rsvd_a = reg_wdata;
				OCS_ADDR_RSVD_B: nxt_state.rsvd_b = reg_wdata;
				OCS_ADDR_RSVD_C: nxt_state.rsvd_c = reg_wdata;
				OCS_ADDR_RSVD_D: nxt_state.rsvd_d = reg_wdata;
				default:         nxt_state.ctrl   = state_ff.ctrl;
			endcase
		end
		if (reg_rd) begin
			nxt_state.rvalid = 1'b1;
			case (reg_addr)
				OCS_ADDR_CTRL:   nxt_state.rdata = state_ff.ctrl;
				OCS_ADDR_RSVD_A: nxt_state.rdata = state_ff.rsvd_a;
				OCS_ADDR_RSVD_B: nxt_state.rdata = state_ff.rsvd_b;
				OCS_ADDR_RSVD_C: nxt_state.rdata = state_ff.rsvd_c;
				OCS_ADDR_RSVD_D: nxt_state.rdata = state_ff.rsvd_d;
				default:         nxt_state.rdata = OCS_UNMAPPED;
			endcase
		end
		nxt_state.route2 = ocs_route(sel2);
		nxt_state.route3 = ocs_route(sel3);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff        <= '0;
			state_ff.ctrl   <= OCS_CTRL_RST;
			state_ff.rsvd_a <= OCS_RSVD_RST;
			state_ff.rsvd_b <= OCS_RSVD_RST;
			state_ff.rsvd_c <= OCS_RSVD_RST;
			state_ff.rsvd_d <= OCS_RSVD_D_RST;
			state_ff.route2 <= 4'h1;
			state_ff.route3 <= 4'h1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata                = state_ff.rdata;
	assign reg_rvalid               = state_ff.rvalid;
	assign div_hold                 = sif.hold;
	assign phase_zero               = sif.phase_zero;
	assign pair_two_source_select   = sel2;
	assign pair_three_source_select = sel3;
	assign pair_two_route           = state_ff.route2;
	assign pair_three_route         = state_ff.route3;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_hold_after_write;
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == OCS_ADDR_CTRL && reg_wdata[OCS_SYNC_BIT])
			|-> ##2 (div_hold[1:0] == 2'b11);
	endproperty
	a_hold_after_write: assert property (p_hold_after_write)
		else $error("PLL pairs not held two cycles after sync write");

	property p_release_after_write;
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == OCS_ADDR_CTRL && !reg_wdata[OCS_SYNC_BIT]
			&& state_ff.ctrl[OCS_SYNC_BIT])
			|-> ##2 (div_hold == 4'h0) && (phase_zero == $past(div_hold));
	endproperty
	a_release_after_write: assert property (p_release_after_write)
		else $error("held dividers not released together with phase clear");

	property p_route_two;
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == OCS_ADDR_CTRL)
			|=> ##1 pair_two_route[$past(reg_wdata[1:0], 2)] && $onehot(pair_two_route);
	endproperty
	a_route_two: assert property (p_route_two)
		else $error("pair two route does not match its code");

	property p_route_three;
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == OCS_ADDR_CTRL)
			|=> ##1 pair_three_route[$past(reg_wdata[5:4], 2)]
				&& $onehot(pair_three_route);
	endproperty
	a_route_three: assert property (p_route_three)
		else $error("pair three route does not match its code");

	property p_non_pll_not_held;
		@(posedge clk) disable iff (rst)
		(pair_two_source_select != OCS_SRC_PLL && $stable(pair_two_source_select))
			|-> !div_hold[2];
	endproperty
	a_non_pll_not_held: assert property (p_non_pll_not_held)
		else $error("non-PLL pair two divider held");

	property p_reserved_readback;
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == OCS_ADDR_RSVD_A)
			##1 !(reg_wr && reg_addr == OCS_ADDR_RSVD_A)
			##1 (reg_rd && !reg_wr && reg_addr == OCS_ADDR_RSVD_A)
			|=> reg_rvalid && (reg_rdata == $past(reg_wdata, 3));
	endproperty
	a_reserved_readback: assert property (p_reserved_readback)
		else $error("reserved register does not read back");

	property p_unmapped_zero;
		@(posedge clk) disable iff (rst)
		(reg_rd && (reg_addr < OCS_ADDR_CTRL || reg_addr > OCS_ADDR_RSVD_D))
			|=> reg_rvalid && (reg_rdata == OCS_UNMAPPED);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");

	property p_three_non_pll_not_held;
		@(posedge clk) disable iff (rst)
		(pair_three_source_select != OCS_SRC_PLL && $stable(pair_three_source_select))
			|-> !div_hold[3];
	endproperty
	a_three_non_pll_not_held: assert property (p_three_non_pll_not_held)
		else $error("non-PLL pair three divider held");

	property p_no_hold_when_clear;
		@(posedge clk) disable iff (rst)
		!state_ff.ctrl[OCS_SYNC_BIT] |=> (div_hold == 4'h0);
	endproperty
	a_no_hold_when_clear: assert property (p_no_hold_when_clear)
		else $error("divider held while sync bit clear");

	property p_phase_only_released;
		@(posedge clk) disable iff (rst)
		(phase_zero != 4'h0) |-> (div_hold == 4'h0);
	endproperty
	a_phase_only_released: assert property (p_phase_only_released)
		else $error("phase cleared on a divider still held");

	property p_select_follows_write;
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == OCS_ADDR_CTRL)
			|=> (pair_two_source_select == $past(reg_wdata[1:0]))
				&& (pair_three_source_select == $past(reg_wdata[5:4]));
	endproperty
	a_select_follows_write: assert property (p_select_follows_write)
		else $error("pair select does not follow control write");

	property p_route_onehot;
		@(posedge clk) disable iff (rst)
		$onehot(pair_two_route) && $onehot(pair_three_route);
	endproperty
	a_route_onehot: assert property (p_route_onehot)
		else $error("pair route is not one-hot");

	// A read is answered on the very next cycle, whatever the address.
	property p_read_answer;
		@(posedge clk) disable iff (rst)
		reg_rd |=> reg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read strobe not answered next cycle");

endmodule

`default_nettype wire

// *** test/ocs_host_model.sv ***
`default_nettype none

module ocs_host_model
	import ocs_pkg::*;
#(
	parameter bit REF0_OVER_LIMIT = 1'b0,  // Reference zero runs above the selectable limit.
	parameter bit REF1_OVER_LIMIT = 1'b0   // Reference one runs above the selectable limit.
) (
	input  wire logic       clk,         // Clock.
	output logic      [7:0] reg_addr,    // Register address.
	output logic      [7:0] reg_wdata,   // Write data.
	output logic            reg_wr,      // Write strobe.
	output logic            reg_rd,      // Read strobe.
	input  wire logic [7:0] reg_rdata,   // Read data.
	input  wire logic       reg_rvalid   // Read data valid pulse.
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Called just after a rising edge; holds the strobe over exactly one edge.
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = (a == OCS_ADDR_CTRL) ? (d & 8'hB3) : 8'h00;
		if (a == OCS_ADDR_CTRL && ((REF0_OVER_LIMIT && v[1:0] == OCS_SRC_REF0) ||
			(REF1_OVER_LIMIT && v[1:0] == OCS_SRC_REF1))) begin
			v[1:0] = OCS_SRC_XTAL;
		end
		if (a == OCS_ADDR_CTRL && ((REF0_OVER_LIMIT && v[5:4] == OCS_SRC_REF0) ||
			(REF1_OVER_LIMIT && v[5:4] == OCS_SRC_REF1))) begin
			v[5:4] = OCS_SRC_XTAL;
		end
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask

	// The answer is registered on the edge that takes the strobe, so it is taken right after
	// that edge; one more edge passes before the next request may start.
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		ok = reg_rvalid;
		d = reg_rdata;
		@(posedge clk);
		#1;
	endtask
endmodule

`default_nettype wire

// *** test/tb.sv ***
`default_nettype none

module tb
	import ocs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic [3:0] div_hold;
	logic [3:0] phase_zero;
	logic [1:0] sel2;
	logic [1:0] sel3;
	logic [3:0] route2;
	logic [3:0] route3;
	int         fails = 0;
	int         check_count = 0;
	int         cycles = 0;

	always #2 clk = ~clk;

	ocs_output_clock_source_sync DUT (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.div_hold(div_hold), .phase_zero(phase_zero), .pair_two_source_select(sel2),
		.pair_three_source_select(sel3), .pair_two_route(route2), .pair_three_route(route3)
	);

	ocs_host_model HOST (
		.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
	);

	task automatic stop_test();
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		HOST.read(a, d, ok);
		chk({name, " valid"}, 8'h01, {7'h00, ok});
		chk(name, exp, d);
	endtask

	task automatic wait_edges(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		chk("hold after reset", 8'h00, {4'h0, div_hold});
		chk("route two after reset", 8'h01, {4'h0, route2});
		rd_chk("control reset", OCS_ADDR_CTRL, OCS_CTRL_RST);
		rd_chk("reserved a reset", OCS_ADDR_RSVD_A, OCS_RSVD_RST);
		rd_chk("reserved d reset", OCS_ADDR_RSVD_D, OCS_RSVD_D_RST);
		rd_chk("unmapped read", 8'h70, OCS_UNMAPPED);
	endtask

	task automatic t_select();
		logic [7:0] d;
		for (int c = 0; c < 4; c++) begin
			d = {2'b00, 2'(3 - c), 2'b00, 2'(c)};
			HOST.write(OCS_ADDR_CTRL, d);
			wait_edges(2);
			chk("select two", {6'h00, 2'(c)}, {6'h00, sel2});
			chk("route two", {4'h0, 4'(4'h1 << c)}, {4'h0, route2});
			chk("select three", {6'h00, 2'(3 - c)}, {6'h00, sel3});
			chk("route three", {4'h0, 4'(4'h1 << (3 - c))}, {4'h0, route3});
			rd_chk("control readback", OCS_ADDR_CTRL, d);
		end
		HOST.write(OCS_ADDR_RSVD_A, 8'hFF);
		wait_edges(1);
		rd_chk("reserved a written", OCS_ADDR_RSVD_A, 8'h00);
		HOST.write(OCS_ADDR_RSVD_B, 8'hFF);
		wait_edges(1);
		rd_chk("reserved b written", OCS_ADDR_RSVD_B, 8'h00);
	endtask

	task automatic t_sync(input logic [1:0] s2, input logic [1:0] s3);
		logic [3:0] exp;
		exp = {s3 == OCS_SRC_PLL, s2 == OCS_SRC_PLL, 2'b11};
		HOST.write(OCS_ADDR_CTRL, {2'b00, s3, 2'b00, s2});
		wait_edges(2);
		HOST.write(OCS_ADDR_CTRL, {2'b10, s3, 2'b00, s2});
		wait_edges(2);
		chk("hold on set", {4'h0, exp}, {4'h0, div_hold});
		wait_edges(5);
		chk("hold kept", {4'h0, exp}, {4'h0, div_hold});
		chk("no phase clear while held", 8'h00, {4'h0, phase_zero});
		HOST.write(OCS_ADDR_CTRL, {2'b00, s3, 2'b00, s2});
		wait_edges(1);
		chk("hold released", 8'h00, {4'h0, div_hold});
		chk("phase cleared", {4'h0, exp}, {4'h0, phase_zero});
		wait_edges(1);
		chk("phase clear pulse", 8'h00, {4'h0, phase_zero});
	endtask

	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_select();
		t_sync(OCS_SRC_PLL, OCS_SRC_PLL);
		t_sync(OCS_SRC_REF0, OCS_SRC_XTAL);
		t_sync(OCS_SRC_XTAL, OCS_SRC_REF1);
		stop_test();
	end
endmodule

`default_nettype wire
